//--- bbs_cfg.svh
// Purpose: Constants for the battery backup sequencer
// Assumes: 100 MHz clock, 1 ms timing tick
// Notes:   Times are in ms, counted on the ms tick
// What this block does
// - Valid DC input alone never turns the backup converter on.
// - Output lost during backup latches backup off until AC is requalified.
// - With DC valid, backup engages after AC-present and bulk-healthy both fall.
// - Backup starts anyway 100 ms after Ac_input_present if bulk stays healthy.
// - AC-to-DC hand-over runs both converters together for about 10 ms.
// - With AC present, backup stays off, armed for an Ac_input_present only while the arm bit is set and bulk, DC and output are good.
// - Main converter returns from backup or latch-off only after AC and bulk good for 1 s.
// - Both converters run together for 0.25 s after main returns.
// - Toggle of AC or bulk indicator restarts the 1 s timing, and drops the 0.25 s overlap back to backup.
// - After the 0.25 s overlap the backup converter phases out in under 20 ms.
// - Supply shuts down after 90 s of continuous backup.
// - Fan runs at full speed throughout a backup phase.
// - No backup engagement while the main converter is in protection shutdown.
`ifndef BBS_CFG_SVH
`define BBS_CFG_SVH

// ============================================================
// Timing
`define BBS_CLK_PERIOD_NS  10
`define BBS_TICK_NS        1000000
`define BBS_TICK_CYCLES    (`BBS_TICK_NS / `BBS_CLK_PERIOD_NS)
`define BBS_ENGAGE_MS      17'd100
`define BBS_AC_OVL_MS      17'd10
`define BBS_QUAL_MS        17'd1000
`define BBS_RET_OVL_MS     17'd250
// Kept below the 20 ms ceiling
`define BBS_PHASE_OUT_MS   17'd19
`define BBS_BACKUP_MAX_MS  17'd90000

// ============================================================
// Register map
`define BBS_REG_CTRL       4'h0
`define BBS_REG_STATUS     4'h4
`define BBS_REG_IRQ_STAT   4'h8
`define BBS_REG_IRQ_MASK   4'hC
`define BBS_CTRL_ARM_BIT   0
`define BBS_CTRL_RESET     8'h01
`define BBS_MASK_RESET     5'h00
`define BBS_IRQ_ENGAGE     0
`define BBS_IRQ_RETURN     1
`define BBS_IRQ_LATCH      2
`define BBS_IRQ_TIMEOUT    3
`define BBS_IRQ_FAULT      4

`endif

//--- bbs_pkg.sv
// Purpose: Types for the battery backup sequencer
// Assumes: Nothing beyond the constants header
// Notes:   States are binary coded
package bbs_pkg;

    // ============================================================
    // Sequencer states
    typedef enum logic [2:0] {
        BBS_ST_AC_IDLE   = 3'b000,
        BBS_ST_WAIT_BULK = 3'b001,
        BBS_ST_AC_TO_DC  = 3'b010,
        BBS_ST_BACKUP    = 3'b011,
        BBS_ST_RET_OVL   = 3'b100,
        BBS_ST_PHASE_OUT = 3'b101,
        BBS_ST_LATCH_OFF = 3'b110,
        BBS_ST_FAULT     = 3'b111
    } bbs_state_t;

    // ============================================================
    // Supervisory indicators
    typedef struct packed {
        logic ac_input_present;
        logic storage_cap_healthy;
        logic dc_input_valid;
        logic output_power_good;
        logic main_prot_shutdown;
    } bbs_inputs_t;

    // Converter and fan commands
    typedef struct packed {
        logic main_en;
        logic backup_en;
        logic backup_phase_out;
        logic fan_full_speed;
    } bbs_outputs_t;

endpackage

//--- bbs_sequencer.sv
// Purpose: Backup converter engage and return sequencing
// Assumes: Indicators arrive asynchronously from analog comparators
// Notes:   All intervals run on a 1 ms tick enable
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "bbs_cfg.svh"

module bbs_sequencer #(
    parameter int TICK_CYCLES            = `BBS_TICK_CYCLES,
    parameter logic [16:0] ENGAGE_MS     = `BBS_ENGAGE_MS,
    parameter logic [16:0] QUAL_MS       = `BBS_QUAL_MS,
    parameter logic [16:0] RET_OVL_MS    = `BBS_RET_OVL_MS,
    parameter logic [16:0] BACKUP_MAX_MS = `BBS_BACKUP_MAX_MS
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    // Supervisory indicators
    input  wire bbs_pkg::bbs_inputs_t ind_in,
    // Converter commands
    output bbs_pkg::bbs_outputs_t     cmd_out,
    // Register port
    input  wire logic [3:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [7:0]                reg_rdata,
    // Interrupt
    output logic                      irq
);
    import bbs_pkg::*;

    // ============================================================
    // Input synchronisers
    bbs_inputs_t meta_r;
    bbs_inputs_t sync_r;
    bbs_inputs_t prev_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= ind_in;
            sync_r <= meta_r;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_r <= '0;
        end else begin
            prev_r <= sync_r;
        end
    end

    logic ac_s;
    logic bulk_s;
    logic dc_s;
    logic pg_s;
    logic prot_s;
    logic ac_fall;
    logic ind_toggle;
    logic qual_ok;

    assign ac_s       = sync_r.ac_input_present;
    assign bulk_s     = sync_r.storage_cap_healthy;
    assign dc_s       = sync_r.dc_input_valid;
    assign pg_s       = sync_r.output_power_good;
    assign prot_s     = sync_r.main_prot_shutdown;
    assign ac_fall    = prev_r.ac_input_present && !ac_s;
    assign ind_toggle = (prev_r.ac_input_present != ac_s) ||
                        (prev_r.storage_cap_healthy != bulk_s);
    assign qual_ok    = ac_s && bulk_s;

    // ============================================================
    // Millisecond tick
    logic [16:0] div_r;
    logic        tick;

    assign tick = (div_r == 17'(TICK_CYCLES - 1));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_r <= '0;
        end else if (tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 17'd1;
        end
    end

    function automatic logic elapsed(input logic [16:0] t, input logic [16:0] lim);
        elapsed = tick && (t >= lim - 17'd1);
    endfunction

    // ============================================================
    // Registers
    logic [7:0] ctrl_r;
    logic [4:0] irq_stat_r;
    logic [4:0] irq_mask_r;
    logic [4:0] irq_ev;
    logic       arm;

    assign arm = ctrl_r[`BBS_CTRL_ARM_BIT];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r     <= `BBS_CTRL_RESET;
            irq_mask_r <= `BBS_MASK_RESET;
        end else if (reg_wr && reg_addr == `BBS_REG_CTRL) begin
            ctrl_r <= reg_wdata;
        end else if (reg_wr && reg_addr == `BBS_REG_IRQ_MASK) begin
            irq_mask_r <= reg_wdata[4:0];
        end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_stat_r <= '0;
        end else if (reg_wr && reg_addr == `BBS_REG_IRQ_STAT) begin
            irq_stat_r <= (irq_stat_r & ~reg_wdata[4:0]) | irq_ev;
        end else begin
            irq_stat_r <= irq_stat_r | irq_ev;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irq_stat_r | irq_ev) & irq_mask_r);
        end
    end

    // ============================================================
    // Sequencer
    bbs_state_t  state_r;
    bbs_state_t  state_nxt;
    logic [16:0] timer_r;
    logic [16:0] bk_ms_r;
    logic        timer_hold;
    logic        bk_run;
    logic        bk_timeout;

    assign bk_run     = (state_r == BBS_ST_AC_TO_DC) || (state_r == BBS_ST_BACKUP) ||
                        (state_r == BBS_ST_RET_OVL);
    assign bk_timeout = bk_run && elapsed(bk_ms_r, BACKUP_MAX_MS);

    // Qualification restarts on any AC or bulk indicator change
    assign timer_hold = ((state_r == BBS_ST_BACKUP) || (state_r == BBS_ST_LATCH_OFF)) &&
                        (!qual_ok || ind_toggle);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            BBS_ST_AC_IDLE: begin
                if (prot_s) begin
                    state_nxt = BBS_ST_FAULT;
                end else if (arm && ac_fall && bulk_s && dc_s && pg_s) begin
                    state_nxt = BBS_ST_WAIT_BULK;
                end
            end
            BBS_ST_WAIT_BULK: begin
                if (prot_s) begin
                    state_nxt = BBS_ST_FAULT;
                end else if (ac_s) begin
                    state_nxt = BBS_ST_AC_IDLE;
                end else if (!bulk_s || elapsed(timer_r, ENGAGE_MS)) begin
                    // Engagement only follows an Ac_input_present seen from idle
                    state_nxt = dc_s ? BBS_ST_AC_TO_DC : BBS_ST_LATCH_OFF;
                end
            end
            BBS_ST_AC_TO_DC: begin
                if (bk_timeout) begin
                    state_nxt = BBS_ST_LATCH_OFF;
                end else if (elapsed(timer_r, `BBS_AC_OVL_MS)) begin
                    state_nxt = BBS_ST_BACKUP;
                end
            end
            BBS_ST_BACKUP: begin
                if (bk_timeout || !pg_s) begin
                    state_nxt = BBS_ST_LATCH_OFF;
                end else if (qual_ok && !ind_toggle && elapsed(timer_r, QUAL_MS)) begin
                    state_nxt = BBS_ST_RET_OVL;
                end
            end
            BBS_ST_RET_OVL: begin
                if (bk_timeout) begin
                    state_nxt = BBS_ST_LATCH_OFF;
                end else if (!qual_ok) begin
                    state_nxt = BBS_ST_BACKUP;
                end else if (elapsed(timer_r, RET_OVL_MS)) begin
                    state_nxt = BBS_ST_PHASE_OUT;
                end
            end
            BBS_ST_PHASE_OUT: begin
                if (elapsed(timer_r, `BBS_PHASE_OUT_MS)) begin
                    state_nxt = BBS_ST_AC_IDLE;
                end
            end
            BBS_ST_LATCH_OFF: begin
                // DC returning alone never restarts backup
                if (qual_ok && !ind_toggle && elapsed(timer_r, QUAL_MS)) begin
                    state_nxt = BBS_ST_AC_IDLE;
                end
            end
            BBS_ST_FAULT: begin
                if (!prot_s && ac_s) begin
                    state_nxt = BBS_ST_AC_IDLE;
                end
            end
            default: begin
                state_nxt = BBS_ST_AC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= BBS_ST_AC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_r <= '0;
        end else if (state_nxt != state_r || timer_hold) begin
            timer_r <= '0;
        end else if (tick && timer_r != 17'h1FFFF) begin
            timer_r <= timer_r + 17'd1;
        end
    end

    // Continuous backup time, cleared once backup ends
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bk_ms_r <= '0;
        end else if (!bk_run) begin
            bk_ms_r <= '0;
        end else if (tick && bk_ms_r != 17'h1FFFF) begin
            bk_ms_r <= bk_ms_r + 17'd1;
        end
    end

    // ============================================================
    // Outputs, registered and aligned with state_r
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_out <= '{main_en: 1'b1, backup_en: 1'b0,
                         backup_phase_out: 1'b0, fan_full_speed: 1'b0};
        end else begin
            cmd_out.main_en <= (state_nxt == BBS_ST_AC_IDLE) ||
                               (state_nxt == BBS_ST_WAIT_BULK) ||
                               (state_nxt == BBS_ST_AC_TO_DC) ||
                               (state_nxt == BBS_ST_RET_OVL) ||
                               (state_nxt == BBS_ST_PHASE_OUT);
            cmd_out.backup_en <= (state_nxt == BBS_ST_AC_TO_DC) ||
                                 (state_nxt == BBS_ST_BACKUP) ||
                                 (state_nxt == BBS_ST_RET_OVL) ||
                                 (state_nxt == BBS_ST_PHASE_OUT);
            cmd_out.backup_phase_out <= (state_nxt == BBS_ST_PHASE_OUT);
            cmd_out.fan_full_speed <= (state_nxt == BBS_ST_AC_TO_DC) ||
                                      (state_nxt == BBS_ST_BACKUP) ||
                                      (state_nxt == BBS_ST_RET_OVL) ||
                                      (state_nxt == BBS_ST_PHASE_OUT);
        end
    end

    assign irq_ev[`BBS_IRQ_ENGAGE]  = (state_nxt == BBS_ST_AC_TO_DC) &&
                                      (state_r != BBS_ST_AC_TO_DC);
    assign irq_ev[`BBS_IRQ_RETURN]  = (state_r == BBS_ST_PHASE_OUT) &&
                                      (state_nxt == BBS_ST_AC_IDLE);
    assign irq_ev[`BBS_IRQ_LATCH]   = (state_nxt == BBS_ST_LATCH_OFF) &&
                                      (state_r != BBS_ST_LATCH_OFF);
    assign irq_ev[`BBS_IRQ_TIMEOUT] = bk_timeout;
    assign irq_ev[`BBS_IRQ_FAULT]   = (state_nxt == BBS_ST_FAULT) &&
                                      (state_r != BBS_ST_FAULT);

    // ============================================================
    // Read port, data one cycle after the strobe only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= '0;
        end else if (!reg_rd) begin
            reg_rdata <= '0;
        end else if (reg_addr == `BBS_REG_CTRL) begin
            reg_rdata <= ctrl_r;
        end else if (reg_addr == `BBS_REG_STATUS) begin
            reg_rdata <= {prot_s, pg_s, dc_s, bulk_s, ac_s, state_r};
        end else if (reg_addr == `BBS_REG_IRQ_STAT) begin
            reg_rdata <= {3'h0, irq_stat_r};
        end else if (reg_addr == `BBS_REG_IRQ_MASK) begin
            reg_rdata <= {3'h0, irq_mask_r};
        end else begin
            reg_rdata <= '0;
        end
    end

    // ============================================================
    // Assertions
    sequence s_wait_then_engage;
        (state_r == BBS_ST_WAIT_BULK) ##1 (state_r == BBS_ST_AC_TO_DC);
    endsequence

    sequence s_ret_then_phase;
        (state_r == BBS_ST_RET_OVL) ##1 (state_r == BBS_ST_PHASE_OUT);
    endsequence

    engage_source_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(cmd_out.backup_en) |-> $past(state_r == BBS_ST_WAIT_BULK) && $past(dc_s))
        else $error("backup enabled without an Ac_input_present path");

    latch_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == BBS_ST_BACKUP && !pg_s) |=> (state_r == BBS_ST_LATCH_OFF) ##1
        !cmd_out.backup_en)
        else $error("backup kept after output loss");

    engage_bulk_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == BBS_ST_WAIT_BULK && !bulk_s && !ac_s && dc_s && !prot_s) |=>
        cmd_out.backup_en && cmd_out.main_en)
        else $error("no engagement after bulk fall");

    engage_timeout_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == BBS_ST_WAIT_BULK) |-> (timer_r < ENGAGE_MS))
        else $error("engagement wait exceeded limit");

    overlap_len_a: assert property (@(posedge clk) disable iff (!reset_n)
        s_wait_then_engage |-> (timer_r == 17'd0) ##1 (cmd_out.main_en && cmd_out.backup_en))
        else $error("hand-over overlap missing");

    idle_backup_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == BBS_ST_AC_IDLE) |-> cmd_out.main_en && !cmd_out.backup_en)
        else $error("backup on in AC idle");

    main_return_a: assert property (@(posedge clk) disable iff (!reset_n)
        ($past(state_r) == BBS_ST_BACKUP && state_r == BBS_ST_RET_OVL) |->
        $past(timer_r) >= QUAL_MS - 17'd1 && $past(qual_ok))
        else $error("main returned before qualification");

    ret_overlap_a: assert property (@(posedge clk) disable iff (!reset_n)
        s_ret_then_phase |-> $past(timer_r, 1) >= RET_OVL_MS - 17'd1 &&
        cmd_out.main_en && cmd_out.backup_en)
        else $error("return overlap cut short");

    qual_restart_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == BBS_ST_BACKUP && ind_toggle && state_nxt == BBS_ST_BACKUP) |=>
        (timer_r == 17'd0))
        else $error("qualification not restarted");

    phase_out_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == BBS_ST_PHASE_OUT) |-> (timer_r < 17'd20) && cmd_out.backup_phase_out)
        else $error("phase out too long");

    backup_limit_a: assert property (@(posedge clk) disable iff (!reset_n)
        bk_run |-> (bk_ms_r < BACKUP_MAX_MS))
        else $error("backup ran past limit");

    fan_full_a: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_out.backup_en |-> cmd_out.fan_full_speed)
        else $error("fan not at full speed in backup");

    prot_block_a: assert property (@(posedge clk) disable iff (!reset_n)
        (prot_s && (state_r == BBS_ST_AC_IDLE || state_r == BBS_ST_WAIT_BULK)) |=>
        (state_r == BBS_ST_FAULT) ##1 !cmd_out.backup_en)
        else $error("engagement possible under protection");

endmodule
`default_nettype wire

//--- bbs_conv_model.sv
// Purpose: Behavioural model of the indicator sources and both converter stages
// Assumes: Voltages given as whole numbers by the bench
// Notes:   Output holds up for a short while after both converters stop
`timescale 1ns/1ns
`default_nettype none

module bbs_conv_model #(
    parameter int HOLD_CYCLES = 20
) (
    // Clock
    input  wire logic                 clk,
    // Analog stand-ins
    input  wire integer               ac_vrms,
    input  wire integer               bulk_pct,
    input  wire integer               dc_volts,
    input  wire logic                 prot_fault,
    // Commands and indicators
    input  wire bbs_pkg::bbs_outputs_t cmd,
    output bbs_pkg::bbs_inputs_t      ind
);
    import bbs_pkg::*;

    logic bulk_ok = 1'b1;
    int   dark_cnt = 0;

    // ============================================================
    // Indicator comparators
    always @(bulk_pct) begin
        if (bulk_pct > 90) begin
            bulk_ok = 1'b1;
        end else if (bulk_pct < 85) begin
            bulk_ok = 1'b0;
        end
    end

    // ============================================================
    // Output rail: falls only after the hold-up time runs out
    always @(posedge clk) begin
        if ((cmd.main_en && bulk_ok) || (cmd.backup_en && ind.dc_input_valid)) begin
            dark_cnt <= 0;
        end else if (dark_cnt < HOLD_CYCLES) begin
            dark_cnt <= dark_cnt + 1;
        end
    end

    assign ind.ac_input_present    = (ac_vrms >= 170);
    assign ind.storage_cap_healthy = bulk_ok;
    assign ind.dc_input_valid      = (dc_volts > 39);
    assign ind.output_power_good   = (dark_cnt < HOLD_CYCLES);
    assign ind.main_prot_shutdown  = prot_fault;

endmodule
`default_nettype wire

//--- tb_battery_backup_sequencer.sv
// Purpose: Self-checking bench for the backup sequencer
// Assumes: Short timing parameters, 10 cycles per ms tick
// Notes:   Read data and command snapshots are checked by a monitor from queues
`timescale 1ns/1ns
`default_nettype none

module tb_battery_backup_sequencer;
    import bbs_pkg::*;

    `define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
        n_mismatch++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

    logic            clk = 1'b0;
    logic            reset_n = 1'b0;
    bbs_inputs_t     ind_in;
    bbs_outputs_t    cmd_out;
    logic [3:0]      reg_addr = 4'h0;
    logic [7:0]      reg_wdata = 8'h00;
    logic            reg_wr = 1'b0;
    logic            reg_rd = 1'b0;
    logic [7:0]      reg_rdata;
    logic            irq;
    int              ac_v = 230;
    int              bulk_p = 100;
    int              dc_v = 48;
    logic            prot = 1'b0;
    logic            cmd_chk = 1'b0;
    logic            rd_prev = 1'b0;
    logic [7:0]      rq[$];
    logic [3:0]      cq[$];
    logic [7:0]      rd_exp;
    logic [3:0]      cmd_exp;
    int              n_mismatch = 0;
    int              checks_done = 0;
    int              seed = 16;
    int              n;

    always #5 clk = ~clk;

    bbs_sequencer #(.TICK_CYCLES(10), .ENGAGE_MS(17'd5), .QUAL_MS(17'd20),
                    .RET_OVL_MS(17'd8), .BACKUP_MAX_MS(17'd200)) dut_u (
        .clk(clk), .reset_n(reset_n), .ind_in(ind_in), .cmd_out(cmd_out),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));

    bbs_conv_model conv_u (
        .clk(clk), .ac_vrms(ac_v), .bulk_pct(bulk_p), .dc_volts(dc_v),
        .prot_fault(prot), .cmd(cmd_out), .ind(ind_in));

    // ============================================================
    // Monitor: oldest note against what appears
    always @(posedge clk) begin
        rd_prev <= reg_rd;
        if (rd_prev) begin
            rd_exp = rq.pop_front();
            `CHK("reg_rdata", rd_exp, reg_rdata)
        end
        if (cmd_chk) begin
            cmd_exp = cq.pop_front();
            `CHK("cmd_out", cmd_exp, cmd_out)
        end
    end

    // ============================================================
    // Drivers
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        rq.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    task automatic note_cmd(input logic [3:0] e);
        @(posedge clk);
        cq.push_back(e);
        cmd_chk <= 1'b1;
        @(posedge clk);
        cmd_chk <= 1'b0;
    endtask

    task automatic set_in(input int ac, input int bulk, input int dc, input logic pf);
        @(posedge clk);
        ac_v <= ac;
        bulk_p <= bulk;
        dc_v <= dc;
        prot <= pf;
    endtask

    // Cycles until a command bit reaches a level, capped at maxc
    task automatic wait_bit(input int idx, input logic v, input int maxc, output int cnt);
        cnt = 0;
        while (cmd_out[idx] !== v && cnt < maxc) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        // A wait that runs out is a failure in its own right
        `CHK("wait_bit", v, cmd_out[idx])
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ============================================================
    // Watchdog, about ten times the expected run
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        summarize();
    end

    // ============================================================
    // Scenarios
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        // Idle after reset, DC valid but no engagement
        note_cmd(4'h8);
        reg_read(4'h0, 8'h01);
        reg_read(4'h4, 8'h78);
        reg_read(4'hC, 8'h00);
        reg_read(4'(($random(seed) & 2) | 1), 8'h00);
        reg_write(4'hC, 8'h1F);
        reg_read(4'hC, 8'h1F);
        // Ac_input_present then bulk loss: engage, overlap, main drops
        set_in(0, 100, 48, 1'b0);
        repeat (10) @(posedge clk);
        set_in(0, 50, 48, 1'b0);
        wait_bit(2, 1'b1, 20, n);
        `CHK("engage", 1'b1, n <= 8)
        note_cmd(4'hD);
        wait_bit(3, 1'b0, 150, n);
        `CHK("ac_to_dc", 1'b1, n >= 80 && n <= 110)
        `CHK("irq", 1'b1, irq)
        reg_read(4'h8, 8'h01);
        reg_write(4'h8, 8'h01);
        reg_read(4'h8, 8'h00);
        #1;
        `CHK("irq", 1'b0, irq)
        // Return with a bulk glitch that restarts qualification
        set_in(230, 100, 48, 1'b0);
        repeat (30 + ($random(seed) & 63)) @(posedge clk);
        set_in(230, 50, 48, 1'b0);
        repeat (5) @(posedge clk);
        set_in(230, 100, 48, 1'b0);
        wait_bit(3, 1'b1, 400, n);
        `CHK("qualify", 1'b1, n >= 180 && n <= 215)
        wait_bit(1, 1'b1, 120, n);
        `CHK("ret_overlap", 1'b1, n >= 70 && n <= 85)
        note_cmd(4'hF);
        wait_bit(2, 1'b0, 250, n);
        `CHK("phase_out", 1'b1, n >= 170 && n < 200)
        note_cmd(4'h8);
        // Bulk stays healthy: engage on timeout, then backup time-out
        set_in(0, 100, 48, 1'b0);
        wait_bit(2, 1'b1, 100, n);
        `CHK("engage_to", 1'b1, n >= 38 && n <= 60)
        wait_bit(2, 1'b0, 2300, n);
        `CHK("backup_max", 1'b1, n >= 1880 && n <= 2010)
        note_cmd(4'h0);
        reg_read(4'h8, 8'h0F);
        reg_write(4'h8, 8'hFF);
        set_in(230, 100, 48, 1'b0);
        wait_bit(3, 1'b1, 400, n);
        `CHK("relatch", 1'b1, n < 400)
        // DC drop during backup latches off; DC return does not resume
        // Let power good settle before the AC fall so idle may engage
        repeat (5) @(posedge clk);
        set_in(0, 100, 48, 1'b0);
        wait_bit(3, 1'b0, 250, n);
        `CHK("dc_backup", 1'b1, n < 250)
        set_in(0, 50, 0, 1'b0);
        wait_bit(2, 1'b0, 100, n);
        `CHK("dc_drop", 1'b1, n < 100)
        set_in(0, 50, 48, 1'b0);
        repeat (100) @(posedge clk);
        note_cmd(4'h0);
        set_in(230, 100, 48, 1'b0);
        wait_bit(3, 1'b1, 400, n);
        // Protection shutdown blocks engagement
        set_in(230, 100, 48, 1'b1);
        repeat (10) @(posedge clk);
        set_in(0, 50, 48, 1'b1);
        repeat (80) @(posedge clk);
        note_cmd(4'h0);
        set_in(230, 100, 48, 1'b0);
        wait_bit(3, 1'b1, 100, n);
        `CHK("fault_exit", 1'b1, n < 100)
        repeat (4) @(posedge clk);
        summarize();
    end

endmodule
`default_nettype wire
